//--- rtl/pmg_pkg.sv
// Package with register map, field positions and reset values of the SECDED guard
package pmg_pkg;
	// Register byte offsets on the Wishbone slave
	localparam logic [7:0] PMG_STATUS_OFS = 8'h00; // Sticky error flags, read only
	localparam logic [7:0] PMG_IRQ_EN_OFS = 8'h04; // Interrupt enable, same layout
	localparam logic [7:0] PMG_CLEAR_OFS  = 8'h08; // Write one to clear, write only
	localparam logic [7:0] PMG_COUNT_OFS  = 8'h0c; // Error count, any write zeroes it
	localparam logic [7:0] PMG_INJECT_OFS = 8'h10; // Error injection control

	// Status, enable and clear bit positions
	localparam int PMG_ST_SINGLE = 0; // Single-bit error corrected
	localparam int PMG_ST_DBL_BUS = 1; // Double-bit error answered with bus error
	localparam int PMG_ST_DBL_STR = 2; // Double-bit error forwarded to stream consumer
	localparam int PMG_ST_W = 3;      // Width of the status layout

	// Injection control field positions
	localparam int PMG_INJ_CNT_LSB = 0; // Bits flipped: 0 none, 1, 2 or 3
	localparam int PMG_INJ_CNT_W = 2;
	localparam int PMG_INJ_POS_LSB = 8; // First codeword bit flipped
	localparam int PMG_INJ_POS_W = 8;

	// Reset values
	localparam logic [PMG_ST_W-1:0] PMG_STATUS_RST = 3'h0;
	localparam logic [PMG_ST_W-1:0] PMG_IRQ_EN_RST = 3'h0;
	localparam logic [PMG_INJ_CNT_W-1:0] PMG_INJ_CNT_RST = 2'h0;
	localparam logic [PMG_INJ_POS_W-1:0] PMG_INJ_POS_RST = 8'h00;

	// Check bits per data width
	function automatic int pmg_chk_w(input int data_w);
		return (data_w > 32) ? 8 : 7;
	endfunction
endpackage

//--- rtl/pmg_mem.sv
// Single-port-write, single-port-read codeword memory with registered read data
`timescale 1ns/1ps
module pmg_mem #(
	parameter int WIDTH = 39,
	parameter int DEPTH = 256,
	parameter int AW    = 8
) (
	input  wire logic             clk_i,
	input  wire logic             wr_en_i,
	input  wire logic [AW-1:0]    wr_addr_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	input  wire logic             rd_en_i,
	input  wire logic [AW-1:0]    rd_addr_i,
	output logic      [WIDTH-1:0] rd_data_o
);
	logic [WIDTH-1:0] store [DEPTH]; // Codeword storage, no reset on purpose

	// Read-first: a read of the address being written returns the old word
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			store[wr_addr_i] <= wr_data_i;
		end
		if (rd_en_i) begin
			rd_data_o <= store[rd_addr_i];
		end
	end
endmodule // pmg_mem

//--- rtl/pmg_guard.sv
// SECDED guard around a peripheral memory, with Wishbone control and status
// Operation
// - 32-bit words store seven check bits
// - 64-bit words store eight check bits
// - Correct single flips, detect double flips
// - Double errors pass data uncorrected
// - Bus reads of double errors answer error
// - Double error interrupts only when enabled
// - Stream reads forward corrupt data, interrupt
// - Status, enable, count, injection per memory
// - Injection flips one, two or three bits
//
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
module pmg_guard
	import pmg_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int DEPTH  = 256,
	parameter int AW     = 8,
	parameter int CNT_W  = 16
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Memory owner write port
	input  wire logic              wr_en_i,
	input  wire logic [AW-1:0]     wr_addr_i,
	input  wire logic [DATA_W-1:0] wr_data_i,
	// Memory owner read port
	input  wire logic              rd_en_i,
	input  wire logic [AW-1:0]     rd_addr_i,
	input  wire logic              rd_bus_i,
	output logic                   rd_valid_o,
	output logic      [DATA_W-1:0] rd_data_o,
	output logic                   rd_err_o,
	output logic                   rd_corrupt_o,
	// Wishbone classic slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// Level interrupt
	output logic                   irq_o
);
	localparam int CHK_W = pmg_chk_w(DATA_W); // 7 or 8 check bits
	localparam int HP    = CHK_W - 1;         // Hamming parity bits
	localparam int CW    = DATA_W + CHK_W;    // Stored codeword width
	localparam int HN    = DATA_W + HP;       // Hamming positions

	// Hamming parity over data placed at non-power-of-two positions
	function automatic logic [HP-1:0] ham_par(input logic [DATA_W-1:0] d);
		logic [HP-1:0] p;
		int            k;
		p = '0;
		k = 1;
		for (int j = 0; j < DATA_W; j++) begin
			k = k + 1;
			while ((k & (k - 1)) == 0) begin
				k = k + 1;
			end
			for (int i = 0; i < HP; i++) begin
				if (k[i]) begin
					p[i] = p[i] ^ d[j];
				end
			end
		end
		return p;
	endfunction

	// Codeword layout: {overall parity, hamming parity, data}
	function automatic logic [CW-1:0] encode(input logic [DATA_W-1:0] d);
		logic [HP-1:0] p;
		p = ham_par(d);
		return {(^d) ^ (^p), p, d};
	endfunction

	// Flip the data bit sitting at hamming position s, if any
	function automatic logic [DATA_W-1:0] fix(input logic [DATA_W-1:0] d,
		input logic [HP-1:0] s);
		logic [DATA_W-1:0] r;
		int                k;
		r = d;
		k = 1;
		for (int j = 0; j < DATA_W; j++) begin
			k = k + 1;
			while ((k & (k - 1)) == 0) begin
				k = k + 1;
			end
			if (k == int'(s)) begin
				r[j] = ~d[j];
			end
		end
		return r;
	endfunction

	// Mask of zero to three adjacent codeword bits starting at pos
	function automatic logic [CW-1:0] inj_mask(input logic [PMG_INJ_CNT_W-1:0] cnt,
		input logic [PMG_INJ_POS_W-1:0] pos);
		logic [CW-1:0] m;
		int            b;
		m = '0;
		for (int n = 0; n < 3; n++) begin
			b = (int'(pos) + n) % CW;
			if (n < int'(cnt)) begin
				m[b] = 1'b1;
			end
		end
		return m;
	endfunction

	// Byte-lane merge for Wishbone writes
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		for (int i = 0; i < 4; i++) begin
			r[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
		return r;
	endfunction

	// Register state
	logic [PMG_ST_W-1:0]      status_reg, status_next;   // Sticky error flags
	logic [PMG_ST_W-1:0]      irq_en_reg, irq_en_next;   // Interrupt enables
	logic [CNT_W-1:0]         count_reg, count_next;     // Saturating error count
	logic [PMG_INJ_CNT_W-1:0] inj_cnt_reg, inj_cnt_next; // Bits to flip, 0 idle
	logic [PMG_INJ_POS_W-1:0] inj_pos_reg, inj_pos_next; // First bit to flip
	logic                     ack_reg, ack_next;
	logic [31:0]              dat_reg, dat_next;
	logic                     irq_reg, irq_next;
	// Read pipeline
	logic                     rpend_reg, rpend_next;     // Memory word valid next cycle
	logic                     rbus_reg, rbus_next;       // Consumer kind of that read
	logic                     rv_reg, rv_next;
	logic [DATA_W-1:0]        rdat_reg, rdat_next;
	logic                     rerr_reg, rerr_next;
	logic                     rcor_reg, rcor_next;

	// Memory side
	logic [CW-1:0]            wr_word;   // Encoded and possibly corrupted word
	logic [CW-1:0]            mem_word;  // Registered word read back
	logic [HP-1:0]            syn;       // Hamming syndrome
	logic                     ovr;       // Overall parity mismatch
	logic                     err_single;
	logic                     err_double;
	logic                     wb_req;    // New Wishbone access this cycle
	logic                     wb_wr;
	logic [31:0]              rd_mux;
	logic [31:0]              inj_word;
	logic [31:0]              inj_wr;

	// Encode and apply any armed injection on the write path
	always_comb begin
		wr_word = encode(wr_data_i);
		if (wr_en_i) begin
			wr_word = wr_word ^ inj_mask(inj_cnt_reg, inj_pos_reg);
		end
	end

	pmg_mem #(
		.WIDTH (CW),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_mem (
		.clk_i     (clk_i),
		.wr_en_i   (wr_en_i),
		.wr_addr_i (wr_addr_i),
		.wr_data_i (wr_word),
		.rd_en_i   (rd_en_i),
		.rd_addr_i (rd_addr_i),
		.rd_data_o (mem_word)
	);

	// Syndrome classification of the stored word
	always_comb begin
		syn        = ham_par(mem_word[DATA_W-1:0]) ^ mem_word[DATA_W +: HP];
		ovr        = ^mem_word;
		err_single = rpend_reg && ovr;
		err_double = rpend_reg && !ovr && (syn != '0);
	end

	// Read-back register mux; the clear register reads as zero
	always_comb begin
		inj_word = '0;
		inj_word[PMG_INJ_CNT_LSB +: PMG_INJ_CNT_W] = inj_cnt_reg;
		inj_word[PMG_INJ_POS_LSB +: PMG_INJ_POS_W] = inj_pos_reg;
		case (wb_adr_i)
			PMG_STATUS_OFS: rd_mux = 32'(status_reg);
			PMG_IRQ_EN_OFS: rd_mux = 32'(irq_en_reg);
			PMG_COUNT_OFS:  rd_mux = 32'(count_reg);
			PMG_INJECT_OFS: rd_mux = inj_word;
			default:        rd_mux = 32'h0000_0000; // Unmapped reads zero
		endcase
	end

	// Next-state logic for bus slave, registers and read pipeline
	always_comb begin
		wb_req       = wb_cyc_i && wb_stb_i && !ack_reg;
		// Commit on the edge where the master samples ack, while it still holds the request
		wb_wr        = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
		ack_next     = wb_req; // One wait state, ack dropped after one cycle
		dat_next     = wb_req ? rd_mux : dat_reg;
		status_next  = status_reg;
		irq_en_next  = irq_en_reg;
		count_next   = count_reg;
		inj_cnt_next = inj_cnt_reg;
		inj_pos_next = inj_pos_reg;
		inj_wr       = lane_merge(inj_word, wb_dat_i, wb_sel_i);

		// Read pipeline: pass raw data on a double error, else corrected data
		rpend_next = rd_en_i;
		rbus_next  = rd_bus_i;
		rv_next    = rpend_reg;
		rdat_next  = rdat_reg;
		rerr_next  = 1'b0;
		rcor_next  = 1'b0;
		if (rpend_reg) begin
			if (err_single && (syn != '0)) begin
				rdat_next = fix(mem_word[DATA_W-1:0], syn);
			end else begin
				rdat_next = mem_word[DATA_W-1:0];
			end
			rerr_next = err_double && rbus_reg;
			rcor_next = err_double && !rbus_reg;
		end

		// Injection disarms once the corrupted write has gone in
		if (wr_en_i) begin
			inj_cnt_next = '0;
		end

		// Software writes; a same-cycle write to a cleared flag loses to the set below
		if (wb_wr) begin
			case (wb_adr_i)
				PMG_IRQ_EN_OFS: begin
					if (wb_sel_i[0]) begin
						irq_en_next = wb_dat_i[PMG_ST_W-1:0];
					end
				end
				PMG_CLEAR_OFS: begin
					if (wb_sel_i[0]) begin
						status_next = status_reg & ~wb_dat_i[PMG_ST_W-1:0];
					end
				end
				PMG_COUNT_OFS: begin
					count_next = '0;
				end
				PMG_INJECT_OFS: begin
					// Arming wins over disarm by a coincident memory write
					inj_cnt_next = inj_wr[PMG_INJ_CNT_LSB +: PMG_INJ_CNT_W];
					inj_pos_next = inj_wr[PMG_INJ_POS_LSB +: PMG_INJ_POS_W];
				end
				default: begin
					// Status and unmapped writes are ignored
				end
			endcase
		end

		// Hardware sets win over software clears
		if (err_single) begin
			status_next[PMG_ST_SINGLE] = 1'b1;
		end
		if (err_double && rbus_reg) begin
			status_next[PMG_ST_DBL_BUS] = 1'b1;
		end
		if (err_double && !rbus_reg) begin
			status_next[PMG_ST_DBL_STR] = 1'b1;
		end
		// Count each detected error, holding at the top value
		if ((err_single || err_double) && (count_next != '1)) begin
			count_next = count_next + CNT_W'(1);
		end

		// Level interrupt while any enabled flag is set
		irq_next = |(status_next & irq_en_next);
	end

	// Register every piece of state; synchronous reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_reg  <= PMG_STATUS_RST;
			irq_en_reg  <= PMG_IRQ_EN_RST;
			count_reg   <= '0;
			inj_cnt_reg <= PMG_INJ_CNT_RST;
			inj_pos_reg <= PMG_INJ_POS_RST;
			ack_reg     <= 1'b0;
			dat_reg     <= 32'h0000_0000;
			irq_reg     <= 1'b0;
			rpend_reg   <= 1'b0;
			rbus_reg    <= 1'b0;
			rv_reg      <= 1'b0;
			rdat_reg    <= '0;
			rerr_reg    <= 1'b0;
			rcor_reg    <= 1'b0;
		end else begin
			status_reg  <= status_next;
			irq_en_reg  <= irq_en_next;
			count_reg   <= count_next;
			inj_cnt_reg <= inj_cnt_next;
			inj_pos_reg <= inj_pos_next;
			ack_reg     <= ack_next;
			dat_reg     <= dat_next;
			irq_reg     <= irq_next;
			rpend_reg   <= rpend_next;
			rbus_reg    <= rbus_next;
			rv_reg      <= rv_next;
			rdat_reg    <= rdat_next;
			rerr_reg    <= rerr_next;
			rcor_reg    <= rcor_next;
		end
	end

	// All outputs straight from flip-flops
	assign wb_ack_o     = ack_reg;
	assign wb_dat_o     = dat_reg;
	assign irq_o        = irq_reg;
	assign rd_valid_o   = rv_reg;
	assign rd_data_o    = rdat_reg;
	assign rd_err_o     = rerr_reg;
	assign rd_corrupt_o = rcor_reg;
endmodule // pmg_guard

//--- tb/pmg_guard_sva.sv
// Port-level checker for the SECDED guard
`timescale 1ns/1ps
module pmg_guard_sva #(
	parameter int DATA_W = 32
) (
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic              rd_en_i,
	input wire logic              rd_bus_i,
	input wire logic              rd_valid_o,
	input wire logic [DATA_W-1:0] rd_data_o,
	input wire logic              rd_err_o,
	input wire logic              rd_corrupt_o,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic [31:0]       wb_dat_o,
	input wire logic              wb_ack_o,
	input wire logic              irq_o
);
	// One clock domain, so one clocking and one disable for all
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_dat_hold;
		!wb_ack_o |-> $stable(wb_dat_o);
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("bus read data moved without ack");
	property p_rd_lat;
		rd_en_i |-> ##2 rd_valid_o;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer not two cycles later");
	property p_rd_src;
		rd_valid_o |-> $past(rd_en_i, 2);
	endproperty
	a_rd_src: assert property (p_rd_src) else $error("read answer without request");
	property p_err;
		rd_err_o |-> rd_valid_o && $past(rd_bus_i, 2);
	endproperty
	a_err: assert property (p_err) else $error("error response outside bus read");
	property p_corrupt;
		rd_corrupt_o |-> rd_valid_o && !$past(rd_bus_i, 2) && !rd_err_o;
	endproperty
	a_corrupt: assert property (p_corrupt) else $error("corrupt mark outside stream read");
	property p_data_hold;
		!rd_valid_o |-> $stable(rd_data_o);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("read data moved without valid");
	property p_irq_cause;
		$rose(irq_o) |-> rd_valid_o || $past(rd_valid_o) || $past(wb_ack_o) || $past(wb_ack_o, 2);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("interrupt rose without cause");
endmodule // pmg_guard_sva

//--- tb/pmg_owner_model.sv
// Behavioural memory owner driving the guard's write and read ports
`timescale 1ns/1ps
module pmg_owner_model (
	input  wire logic        clk_i,
	input  wire logic        rd_valid_i,
	input  wire logic [31:0] rd_data_i,
	input  wire logic        rd_err_i,
	input  wire logic        rd_corrupt_i,
	output logic             wr_en_o,
	output logic [7:0]       wr_addr_o,
	output logic [31:0]      wr_data_o,
	output logic             rd_en_o,
	output logic [7:0]       rd_addr_o,
	output logic             rd_bus_o
);
	logic        v, e, c;   // Flags captured with the answer
	logic [31:0] q;         // Word captured with the answer
	int          n_recover; // Faulty reads that start recovery
	initial begin
		{wr_en_o, rd_en_o, rd_bus_o} = 3'h0;
		{wr_addr_o, rd_addr_o, wr_data_o} = 48'h0;
		n_recover = 0;
	end
	// One word, strobe one cycle; lines inverted after so stale data never looks valid
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wr_en_o <= 1'b1;
		wr_addr_o <= a;
		wr_data_o <= d;
		@(posedge clk_i);
		wr_en_o <= 1'b0;
		wr_addr_o <= ~a;
		wr_data_o <= ~d;
		@(posedge clk_i);
	endtask
	// Answer is taken two cycles after the taking edge
	task automatic rd(input logic [7:0] a, input logic b);
		rd_en_o <= 1'b1;
		rd_addr_o <= a;
		rd_bus_o <= b;
		@(posedge clk_i);
		rd_en_o <= 1'b0;
		rd_addr_o <= ~a;
		repeat (2) @(posedge clk_i);
		{v, e, c, q} = {rd_valid_i, rd_err_i, rd_corrupt_i, rd_data_i};
		if (e || c) n_recover++;
	endtask
endmodule // pmg_owner_model

//--- tb/pmg_guard_bench.sv
// Self-checking bench for the SECDED guard
`timescale 1ns/1ps
module pmg_guard_bench;
	import pmg_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_data_o, wr_data_i, rdat;
	logic        wr_en_i, rd_en_i, rd_bus_i, rd_valid_o, rd_err_o, rd_corrupt_o, wb_ack_o, irq_o;
	logic [7:0]  wr_addr_i, rd_addr_i;
	logic [63:0] rd_data64;                  // Read data of the 64-bit guard
	logic        rd_err64, rd_corrupt64, irq64;
	int          mismatches = 0, n_tests = 0, cycles = 0;
	logic [7:0]  ofs [6] = '{PMG_STATUS_OFS, PMG_IRQ_EN_OFS, PMG_CLEAR_OFS, PMG_COUNT_OFS,
		PMG_INJECT_OFS, 8'h40};
	pmg_guard i_dut (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i),
		.wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .rd_bus_i(rd_bus_i),
		.rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_err_o(rd_err_o),
		.rd_corrupt_o(rd_corrupt_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .irq_o(irq_o));
	pmg_owner_model i_own (.clk_i(clk_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
		.rd_err_i(rd_err_o), .rd_corrupt_i(rd_corrupt_o), .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i),
		.wr_data_o(wr_data_i), .rd_en_o(rd_en_i), .rd_addr_o(rd_addr_i), .rd_bus_o(rd_bus_i));
	// Second guard on 64-bit words, same traffic with an inverted upper half
	pmg_guard #(.DATA_W(64)) i_dut64 (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en_i),
		.wr_addr_i(wr_addr_i), .wr_data_i({~wr_data_i, wr_data_i}), .rd_en_i(rd_en_i),
		.rd_addr_i(rd_addr_i), .rd_bus_i(rd_bus_i), .rd_valid_o(), .rd_data_o(rd_data64),
		.rd_err_o(rd_err64), .rd_corrupt_o(rd_corrupt64), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(), .wb_ack_o(), .irq_o(irq64));
	// 40 ns clock
	initial forever #20 clk_i = ~clk_i;
	// Hang guard, far beyond the hundred-odd cycles the run needs
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// Classic cycle: hold everything until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		{wb_cyc_i, wb_stb_i} <= 2'h3;
		{wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {w, a, d, s};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		rdat = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
		@(posedge clk_i);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string n);
		wb(1'b0, a, 32'h0, 4'hf);
		check(n, rdat, exp);
	endtask
	function automatic logic [31:0] inj(input int n, input int p);
		return (32'(p) << PMG_INJ_POS_LSB) | 32'(n);
	endfunction
	task automatic complete_run();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		foreach (ofs[i]) rreg(ofs[i], 32'h0, "reset or unmapped");
		wb(1'b1, PMG_STATUS_OFS, 32'h7, 4'hf);
		rreg(PMG_STATUS_OFS, 32'h0, "status read only");
		i_own.wr(8'h01, 32'ha5a5_0f0f);
		i_own.rd(8'h01, 1'b1);
		check("clean word", i_own.q, 32'ha5a5_0f0f);
		check("clean flags", {i_own.v, i_own.e, i_own.c}, 3'h4);
		check("wide clean", rd_data64[63:32], ~32'ha5a5_0f0f);
		// Single flip, disarm and sticky flag
		wb(1'b1, PMG_INJECT_OFS, inj(1, 4), 4'h3);
		i_own.wr(8'h02, 32'h1234_5678);
		rreg(PMG_INJECT_OFS, inj(0, 4), "inject disarm");
		i_own.rd(8'h02, 1'b1);
		check("corrected word", i_own.q, 32'h1234_5678);
		check("single no error", {i_own.e, i_own.c}, 2'h0);
		check("wide corrected", rd_data64[31:0], 32'h1234_5678);
		rreg(PMG_STATUS_OFS, 32'h1 << PMG_ST_SINGLE, "single flag");
		rreg(PMG_COUNT_OFS, 32'h1, "count one");
		wb(1'b1, PMG_IRQ_EN_OFS, 32'h7, 4'hf);
		rreg(PMG_IRQ_EN_OFS, 32'h7, "enable");
		check("irq enabled", irq_o, 1'b1);
		wb(1'b1, PMG_CLEAR_OFS, 32'h7, 4'hf);
		rreg(PMG_STATUS_OFS, 32'h0, "cleared");
		check("irq cleared", irq_o, 1'b0);
		wb(1'b1, PMG_IRQ_EN_OFS, 32'h0, 4'hf);
		// Double flip on a bus read: raw word and error response
		wb(1'b1, PMG_INJECT_OFS, inj(2, 0), 4'h3);
		i_own.wr(8'h03, 32'hdead_beef);
		i_own.rd(8'h03, 1'b1);
		check("double raw", i_own.q, 32'hdead_beef ^ 32'h3);
		check("bus error", {i_own.e, i_own.c}, 2'h2);
		check("wide raw", rd_data64[31:0], 32'hdead_beef ^ 32'h3);
		rreg(PMG_STATUS_OFS, 32'h1 << PMG_ST_DBL_BUS, "double bus flag");
		check("irq masked", irq_o, 1'b0);
		wb(1'b1, PMG_IRQ_EN_OFS, 32'h1 << PMG_ST_DBL_BUS, 4'hf);
		rreg(PMG_COUNT_OFS, 32'h2, "count two");
		check("irq unmasked", irq_o, 1'b1);
		check("wide irq", irq64, 1'b1);
		// Double flip on a stream read: forwarded corrupt
		wb(1'b1, PMG_INJECT_OFS, inj(2, 0), 4'h3);
		i_own.wr(8'h04, 32'h0f0f_00ff);
		i_own.rd(8'h04, 1'b0);
		check("stream raw", i_own.q, 32'h0f0f_00ff ^ 32'h3);
		check("stream corrupt", {i_own.e, i_own.c}, 2'h1);
		rreg(PMG_STATUS_OFS, 32'h6, "both double flags");
		rreg(PMG_COUNT_OFS, 32'h3, "count three");
		// Stream double alone must raise the interrupt once its enable is set
		wb(1'b1, PMG_CLEAR_OFS, 32'h1 << PMG_ST_DBL_BUS, 4'hf);
		check("irq bus flag cleared", irq_o, 1'b0);
		wb(1'b1, PMG_IRQ_EN_OFS, 32'h1 << PMG_ST_DBL_STR, 4'hf);
		check("irq stream", irq_o, 1'b1);
		wb(1'b1, PMG_COUNT_OFS, 32'h0, 4'hf);
		// Triple flip decodes as a single error
		wb(1'b1, PMG_INJECT_OFS, inj(3, 0), 4'h3);
		i_own.wr(8'h05, 32'h5555_aaaa);
		i_own.rd(8'h05, 1'b1);
		rreg(PMG_COUNT_OFS, 32'h1, "triple counted");
		check("triple raw", i_own.q, 32'h5555_aaaa ^ 32'h7);
		check("recoveries", i_own.n_recover, 32'h2);
		complete_run();
	end
endmodule // pmg_guard_bench
bind pmg_guard pmg_guard_sva #(.DATA_W(DATA_W)) i_sva (.clk_i(clk_i), .rst_i(rst_i),
	.rd_en_i(rd_en_i), .rd_bus_i(rd_bus_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
	.rd_err_o(rd_err_o), .rd_corrupt_o(rd_corrupt_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
